// ### dsau_agu.v
// One address generation unit: forms and post-modifies an effective byte address
`timescale 1ns/1ps
`default_nettype none
`include "dsau_consts.vh"

module dsau_agu (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire valid_i,
    input wire byte_op_i,
    input wire [1:0] mode_i,
    input wire [15:0] direct_addr_i,
    input wire [12:0] near_addr_i,
    input wire [15:0] source_pointer_register_i,
    output wire [15:0] effective_byte_address_o,
    output wire misaligned_o,
    output reg [15:0] next_pointer_o
);
    localparam MODE_DIRECT = 2'h0;
    localparam MODE_NEAR = 2'h1;
    localparam MODE_INDIRECT = 2'h2;
    localparam MODE_POSTINC = 2'h3;

    reg [15:0] ea;

    always @* begin
        case (mode_i)
            MODE_DIRECT: ea = direct_addr_i; // see (R20)
            MODE_NEAR: ea = {`DSAU_NEAR_PAD, near_addr_i}; // see (R19)
            MODE_INDIRECT: ea = source_pointer_register_i; // see (R20)
            MODE_POSTINC: ea = source_pointer_register_i;
            default: ea = source_pointer_register_i;
        endcase
    end

    assign effective_byte_address_o = ea; // see (R06)
    assign misaligned_o = valid_i & ~byte_op_i & ea[0]; // see (R13)

    // Pointer write-back is registered so the core sees it next cycle
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            next_pointer_o <= `DSAU_ZERO_WORD;
        end else if (valid_i && mode_i == MODE_POSTINC) begin
            next_pointer_o <= source_pointer_register_i + (byte_op_i ? `DSAU_BYTE_STEP : `DSAU_WORD_STEP); // see (R10)
        end
    end
endmodule
`default_nettype wire

// ### dsau_checker.sv
// Port assertions for the data space access unit
`timescale 1ns/1ps
`default_nettype none
module dsau_checker (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire rd_valid_i,
    input wire rd_byte_i,
    input wire [1:0] rd_mode_i,
    input wire [15:0] rd_pointer_i,
    input wire wr_valid_i,
    input wire wr_byte_i,
    input wire pc_advance_i,
    input wire pc_load_i,
    input wire rd_data_valid_o,
    input wire [15:0] rd_next_pointer_o,
    input wire [15:0] rd_effective_byte_address_o,
    input wire [15:0] wr_effective_byte_address_o,
    input wire [1:0] sfr_byte_strobe_o,
    input wire addr_error_o,
    input wire addr_error_write_o,
    input wire [22:0] pc_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_rd_odd;
        rd_valid_i && !rd_byte_i && rd_effective_byte_address_o[0];
    endsequence
    sequence s_wr_odd;
        wr_valid_i && !wr_byte_i && wr_effective_byte_address_o[0];
    endsequence
    a_read_answer: assert property (rd_valid_i |=> rd_data_valid_o)
        else $error("read not answered");
    a_read_misalign: assert property (s_rd_odd |=> addr_error_o)
        else $error("odd word read without fault");
    a_write_fault: assert property (s_wr_odd |=> addr_error_o && addr_error_write_o)
        else $error("odd word write fault wrong");
    a_write_blocked: assert property (s_wr_odd |-> sfr_byte_strobe_o == 2'b00)
        else $error("odd word write not blocked");
    a_fault_cause: assert property (addr_error_o |-> $past(rd_valid_i && !rd_byte_i && rd_effective_byte_address_o[0]
        || wr_valid_i && !wr_byte_i && wr_effective_byte_address_o[0]))
        else $error("fault without cause");
    a_byte_lane: assert property (wr_valid_i && wr_byte_i && wr_effective_byte_address_o < 16'h0800
        |-> sfr_byte_strobe_o == (wr_effective_byte_address_o[0] ? 2'b10 : 2'b01))
        else $error("byte strobe wrong");
    a_post_inc: assert property (rd_valid_i && rd_mode_i == 2'd3
        |=> rd_next_pointer_o == $past(rd_pointer_i) + ($past(rd_byte_i) ? 16'h0001 : 16'h0002))
        else $error("post increment wrong");
    a_pc_step: assert property (pc_advance_i && !pc_load_i |=> pc_o == $past(pc_o) + 23'h000002)
        else $error("pc step wrong");
endmodule
bind dsau_top dsau_checker u_dsau_checker (.*);
`default_nettype wire

// ### dsau_consts.vh
// Constants for the data space access unit
`ifndef DSAU_CONSTS_VH
`define DSAU_CONSTS_VH

`define DSAU_RESET_PC 23'h000000
`define DSAU_GOTO_OPERAND 23'h000002
`define DSAU_VEC_END 23'h000200
`define DSAU_IVT_START 23'h000004
`define DSAU_IVT_END 23'h0000ff
`define DSAU_AIVT_START 23'h000100
`define DSAU_AIVT_END 23'h0001ff
`define DSAU_PC_STEP 23'h000002
`define DSAU_SFR_END 16'h07ff
`define DSAU_NEAR_END 16'h1fff
`define DSAU_RAM_END 16'h77ff
`define DSAU_PSV_BIT 15
`define DSAU_BYTE_STEP 16'h0001
`define DSAU_WORD_STEP 16'h0002
`define DSAU_ZERO_WORD 16'h0000
`define DSAU_NEAR_PAD 3'h0
`define DSAU_PM_UNIMPL 8'h00

`endif

// ### dsau_pc.v
// Program counter stepping and vector region classification
`timescale 1ns/1ps
`default_nettype none
`include "dsau_consts.vh"

module dsau_pc (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire advance_i,
    input wire load_i,
    input wire [22:0] load_addr_i,
    output reg [22:0] pc_o,
    output wire in_vector_area_o,
    output wire in_ivt_o,
    output wire in_aivt_o
);
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pc_o <= `DSAU_RESET_PC; // see (R04)
        end else if (load_i) begin
            pc_o <= {load_addr_i[22:1], 1'b0}; // see (R01) (R22)
        end else if (advance_i) begin
            pc_o <= pc_o + `DSAU_PC_STEP; // see (R01)
        end
    end

    assign in_vector_area_o = pc_o < `DSAU_VEC_END; // see (R03)
    assign in_ivt_o = pc_o >= `DSAU_IVT_START && pc_o <= `DSAU_IVT_END; // see (R05)
    assign in_aivt_o = pc_o >= `DSAU_AIVT_START && pc_o <= `DSAU_AIVT_END; // see (R05)
endmodule
`default_nettype wire

// ### dsau_sfr_model.sv
// Far-side model: special function registers and program view window
`timescale 1ns/1ps
`default_nettype none
module dsau_sfr_model (
    input wire logic [15:0] addr_i,
    output logic [15:0] sfr_rdata_o,
    output logic sfr_hit_o,
    output logic [15:0] psv_rdata_o
);
    // One implemented register; elsewhere the bus shows junk, not zero
    assign sfr_hit_o = (addr_i[15:1] == 15'h0010);
    assign sfr_rdata_o = sfr_hit_o ? 16'h1234 : ~addr_i;
    assign psv_rdata_o = {addr_i[7:0], 8'hc3};
endmodule
`default_nettype wire

// ### dsau_top.v
// Data space access unit: decode, byte lanes, traps, program fetch
`timescale 1ns/1ps
`default_nettype none
`include "dsau_consts.vh"

// What this block does
// (R01) Program counter word-aligned, steps by two per instruction word.
// (R02) Program word: lower half even address, upper half odd, top byte zero.
// (R03) Addresses below 0x200 are the vector area, not general code.
// (R04) Fetch starts at zero after reset; start address operand at two.
// (R05) Two interrupt vector tables: 0x004-0x0ff and 0x100-0x1ff.
// (R06) Effective addresses are 16-bit byte addresses over 64 Kbytes.
// (R07) Bit 15 clear selects data memory; set selects program view window.
// (R08) Reads outside the implemented 30 Kbytes return zero.
// (R09) Low byte at even address, high byte at odd address.
// (R10) Post-increment adds one for bytes, two for words.
// (R11) Byte read picks byte by bit 0 onto the low lane.
// (R12) Shared word decode, separate byte strobes; byte write hits one lane.
// (R13) Word access at odd address raises an address error.
// (R14) Misaligned read completes; misaligned write is suppressed; then trap.
// (R15) Byte load into working register changes only its low byte.
// (R16) Sign-extend and zero-extend operations on working register bytes.
// (R17) Addresses 0x0000-0x07ff go to special function registers.
// (R18) Unused special function register addresses read zero.
// (R19) Near area 0x0000-0x1fff reachable by 13-bit direct field.
// (R20) Whole space reachable by 16-bit direct or register indirect.
// (R21) Separate address generation units for reads and writes.
// (R22) User program access limited to 0x000000-0x7fffff.
// (R23) Address error reported as one pulse per faulting cycle with read/write flag; a read and write faulting together give one pulse.
module dsau_top #(
    parameter RAM_WORDS = 1024
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Read request
    input wire rd_valid_i,
    input wire rd_byte_i,
    input wire [1:0] rd_mode_i,
    input wire [15:0] rd_direct_addr_i,
    input wire [12:0] rd_near_addr_i,
    input wire [15:0] rd_pointer_i,
    // Write request
    input wire wr_valid_i,
    input wire wr_byte_i,
    input wire [1:0] wr_mode_i,
    input wire [15:0] wr_direct_addr_i,
    input wire [12:0] wr_near_addr_i,
    input wire [15:0] wr_pointer_i,
    input wire [15:0] wr_data_i,
    // Working register update path
    input wire [15:0] wreg_old_i,
    input wire sign_extend_op_i,
    input wire zero_extend_op_i,
    // Program fetch
    input wire pc_advance_i,
    input wire pc_load_i,
    input wire [22:0] pc_load_addr_i,
    input wire [23:0] pm_word_i,
    // Special function register and program window side
    input wire [15:0] sfr_rdata_i,
    input wire sfr_hit_i,
    input wire [15:0] psv_rdata_i,
    // Results
    output reg [15:0] rd_data_o,
    output reg rd_data_valid_o,
    output reg [15:0] wreg_new_o,
    output wire [15:0] rd_next_pointer_o,
    output wire [15:0] wr_next_pointer_o,
    output wire [15:0] rd_effective_byte_address_o,
    output wire [15:0] wr_effective_byte_address_o,
    output wire sfr_wr_en_o,
    output wire [1:0] sfr_byte_strobe_o,
    output wire [15:0] sfr_wdata_o,
    output wire psv_rd_o,
    output reg addr_error_o,
    output reg addr_error_write_o,
    output wire [22:0] pc_o,
    output reg [15:0] pm_lower_word_o,
    output reg [15:0] pm_upper_word_o,
    output wire in_vector_area_o,
    output wire in_ivt_o,
    output wire in_aivt_o
);
    localparam AW = $clog2(RAM_WORDS);

    reg [15:0] ram [0:RAM_WORDS-1];

    wire [15:0] rd_ea;
    wire [15:0] wr_ea;
    wire rd_mis;
    wire wr_mis;

    // Two independent generators keep read and write addresses apart
    dsau_agu u_rd_agu ( // see (R21)
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .valid_i(rd_valid_i),
        .byte_op_i(rd_byte_i),
        .mode_i(rd_mode_i),
        .direct_addr_i(rd_direct_addr_i),
        .near_addr_i(rd_near_addr_i),
        .source_pointer_register_i(rd_pointer_i),
        .effective_byte_address_o(rd_ea),
        .misaligned_o(rd_mis),
        .next_pointer_o(rd_next_pointer_o)
    );

    dsau_agu u_wr_agu ( // see (R21)
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .valid_i(wr_valid_i),
        .byte_op_i(wr_byte_i),
        .mode_i(wr_mode_i),
        .direct_addr_i(wr_direct_addr_i),
        .near_addr_i(wr_near_addr_i),
        .source_pointer_register_i(wr_pointer_i),
        .effective_byte_address_o(wr_ea),
        .misaligned_o(wr_mis),
        .next_pointer_o(wr_next_pointer_o)
    );

    dsau_pc u_pc (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .advance_i(pc_advance_i),
        .load_i(pc_load_i),
        .load_addr_i(pc_load_addr_i),
        .pc_o(pc_o),
        .in_vector_area_o(in_vector_area_o),
        .in_ivt_o(in_ivt_o),
        .in_aivt_o(in_aivt_o)
    );

    assign rd_effective_byte_address_o = rd_ea;
    assign wr_effective_byte_address_o = wr_ea;

    // Region decode, one separate copy for each side
    wire rd_psv = rd_ea[`DSAU_PSV_BIT]; // see (R07)
    wire rd_sfr = ~rd_psv && rd_ea <= `DSAU_SFR_END; // see (R17)
    wire rd_ram = ~rd_psv && ~rd_sfr && rd_ea <= `DSAU_RAM_END;
    wire [15:0] rd_ram_off = rd_ea - `DSAU_SFR_END - 16'h0001;
    wire rd_ram_hit = rd_ram && (rd_ram_off[15:1] < RAM_WORDS); // see (R08)

    wire wr_psv = wr_ea[`DSAU_PSV_BIT];
    wire wr_sfr = ~wr_psv && wr_ea <= `DSAU_SFR_END;
    wire [15:0] wr_ram_off = wr_ea - `DSAU_SFR_END - 16'h0001;
    wire wr_ram_hit = ~wr_psv && ~wr_sfr && wr_ea <= `DSAU_RAM_END && (wr_ram_off[15:1] < RAM_WORDS);

    // Suppress the store on a misaligned word write, instruction still retires
    wire wr_go = wr_valid_i & ~wr_mis; // see (R14)
    wire [1:0] lanes = wr_byte_i ? (wr_ea[0] ? 2'b10 : 2'b01) : 2'b11; // see (R12) (R09)
    wire [15:0] wdata_lane = wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]} : wr_data_i;

    assign sfr_wr_en_o = wr_go & wr_sfr;
    assign sfr_byte_strobe_o = (wr_go & wr_sfr) ? lanes : 2'b00;
    assign sfr_wdata_o = wdata_lane;
    assign psv_rd_o = rd_valid_i & rd_psv;

    always @(posedge sys_clk_i) begin
        if (wr_go && wr_ram_hit) begin
            if (lanes[0]) begin
                ram[wr_ram_off[AW:1]][7:0] <= wdata_lane[7:0]; // see (R12)
            end
            if (lanes[1]) begin
                ram[wr_ram_off[AW:1]][15:8] <= wdata_lane[15:8];
            end
        end
    end

    // Read word selection
    reg [15:0] word;
    reg [7:0] sel_byte;
    reg [15:0] rd_value;

    always @* begin
        if (rd_psv) begin
            word = psv_rdata_i;
        end else if (rd_sfr) begin
            word = sfr_hit_i ? sfr_rdata_i : `DSAU_ZERO_WORD; // see (R18)
        end else if (rd_ram_hit) begin
            word = ram[rd_ram_off[AW:1]];
        end else begin
            word = `DSAU_ZERO_WORD; // see (R08)
        end
        sel_byte = rd_ea[0] ? word[15:8] : word[7:0]; // see (R11) (R09)
        rd_value = rd_byte_i ? {8'h00, sel_byte} : word;
    end

    // Misaligned read still returns data; the trap follows completion
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= `DSAU_ZERO_WORD;
            rd_data_valid_o <= 1'b0;
            wreg_new_o <= `DSAU_ZERO_WORD;
        end else begin
            rd_data_valid_o <= rd_valid_i; // see (R14)
            if (rd_valid_i) begin
                rd_data_o <= rd_value;
                if (sign_extend_op_i) begin
                    wreg_new_o <= {{8{sel_byte[7]}}, sel_byte}; // see (R16)
                end else if (zero_extend_op_i) begin
                    wreg_new_o <= {8'h00, sel_byte}; // see (R16)
                end else if (rd_byte_i) begin
                    wreg_new_o <= {wreg_old_i[15:8], sel_byte}; // see (R15)
                end else begin
                    wreg_new_o <= word;
                end
            end
        end
    end

    // One pulse per cycle with a faulting access; write flagged when write faults
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            addr_error_o <= 1'b0;
            addr_error_write_o <= 1'b0;
        end else begin
            addr_error_o <= rd_mis | wr_mis; // see (R13) (R23)
            addr_error_write_o <= wr_mis; // see (R23)
        end
    end

    // Program word split into two 16-bit halves
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pm_lower_word_o <= `DSAU_ZERO_WORD;
            pm_upper_word_o <= `DSAU_ZERO_WORD;
        end else begin
            pm_lower_word_o <= pm_word_i[15:0]; // see (R02)
            pm_upper_word_o <= {`DSAU_PM_UNIMPL, pm_word_i[23:16]}; // see (R02)
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the data space access unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk_i, sys_rst_i, rd_valid_i, rd_byte_i, wr_valid_i, wr_byte_i, sign_extend_op_i, zero_extend_op_i;
    logic pc_advance_i, pc_load_i, sfr_hit_i, rd_data_valid_o, sfr_wr_en_o, psv_rd_o, addr_error_o;
    logic addr_error_write_o, in_vector_area_o, in_ivt_o, in_aivt_o;
    logic [1:0] rd_mode_i, wr_mode_i, sfr_byte_strobe_o;
    logic [12:0] rd_near_addr_i, wr_near_addr_i;
    logic [15:0] rd_direct_addr_i, rd_pointer_i, wr_direct_addr_i, wr_pointer_i, wr_data_i, wreg_old_i;
    logic [15:0] sfr_rdata_i, psv_rdata_i, rd_data_o, wreg_new_o, rd_next_pointer_o, wr_next_pointer_o;
    logic [15:0] rd_effective_byte_address_o, wr_effective_byte_address_o, sfr_wdata_o;
    logic [15:0] pm_lower_word_o, pm_upper_word_o;
    logic [22:0] pc_load_addr_i, pc_o;
    logic [23:0] pm_word_i;
    int miscompares, compares, cycles;
    dsau_top #(.RAM_WORDS(1024)) u_dsau_top (.*);
    dsau_sfr_model u_dsau_sfr_model (.addr_i(rd_effective_byte_address_o), .sfr_rdata_o(sfr_rdata_i),
        .sfr_hit_o(sfr_hit_i), .psv_rdata_o(psv_rdata_i));
    task automatic chk(input string what, input logic [22:0] seen, input logic [22:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Leaves the request up so reads can run back to back
    task automatic rd(input logic [1:0] m, input logic b, input logic [15:0] a);
        rd_mode_i = m;
        rd_byte_i = b;
        rd_direct_addr_i = a;
        rd_near_addr_i = a[12:0];
        rd_pointer_i = a;
        rd_valid_i = 1'b1;
        @(negedge sys_clk_i);
        chk("read valid", rd_data_valid_o, 1'b1);
    endtask
    task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d);
        wr_byte_i = b;
        wr_direct_addr_i = a;
        wr_data_i = d;
        wr_valid_i = 1'b1;
        @(negedge sys_clk_i);
    endtask
    task automatic idle;
        rd_valid_i = 1'b0;
        wr_valid_i = 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic ld(input logic [22:0] a);
        pc_load_addr_i = a;
        pc_load_i = 1'b1;
        @(negedge sys_clk_i);
        pc_load_i = 1'b0;
    endtask
    task automatic t_program;
        chk("reset pc", pc_o, 23'h000000);
        chk("vector area", in_vector_area_o, 1'b1);
        pc_advance_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        pc_advance_i = 1'b0;
        chk("pc step", pc_o, 23'h000006);
        chk("first table", in_ivt_o, 1'b1);
        ld(23'h000101);
        chk("pc aligned", pc_o, 23'h000100);
        chk("second table", in_aivt_o, 1'b1);
        ld(23'h000200);
        chk("code area", in_vector_area_o, 1'b0);
        chk("pm lower", pm_lower_word_o, 16'hcdef);
        chk("pm upper", pm_upper_word_o, 16'h00ab);
        $display("program test done");
    endtask
    task automatic t_data;
        wr(1'b0, 16'h0800, 16'hbeef);
        wr(1'b1, 16'h0801, 16'h005a);
        wr(1'b1, 16'h0802, 16'h0085);
        wr(1'b0, 16'h0804, 16'h2222);
        wr(1'b0, 16'h0805, 16'h1111);
        chk("write fault", {addr_error_o, addr_error_write_o}, 2'b11);
        idle;
        rd(2'd0, 1'b0, 16'h0800);
        chk("word lanes", rd_data_o, 16'h5aef);
        rd(2'd1, 1'b1, 16'h0801);
        chk("odd byte", rd_data_o, 16'h005a);
        rd(2'd3, 1'b1, 16'h0802);
        chk("even byte", rd_data_o, 16'h0085);
        chk("post inc", rd_next_pointer_o, 16'h0803);
        rd(2'd0, 1'b0, 16'h0804);
        chk("write blocked", rd_data_o, 16'h2222);
        rd(2'd2, 1'b0, 16'h0805);
        chk("read fault", {addr_error_o, addr_error_write_o}, 2'b10);
        rd(2'd0, 1'b0, 16'h7800);
        chk("outside", rd_data_o, 16'h0000);
        rd(2'd0, 1'b0, 16'h0040);
        chk("unused reg", rd_data_o, 16'h0000);
        rd(2'd0, 1'b0, 16'h0020);
        chk("reg read", rd_data_o, 16'h1234);
        rd(2'd2, 1'b0, 16'h8010);
        chk("window read", rd_data_o, 16'h10c3);
        chk("window strobe", psv_rd_o, 1'b1);
        chk("read address", rd_effective_byte_address_o, 16'h8010);
        idle;
        $display("data test done");
    endtask
    task automatic t_extend;
        wreg_old_i = 16'hab00;
        rd(2'd0, 1'b1, 16'h0802);
        chk("byte load", wreg_new_o, 16'hab85);
        sign_extend_op_i = 1'b1;
        rd(2'd0, 1'b1, 16'h0802);
        chk("sign extend", wreg_new_o, 16'hff85);
        sign_extend_op_i = 1'b0;
        zero_extend_op_i = 1'b1;
        rd(2'd0, 1'b1, 16'h0802);
        chk("zero extend", wreg_new_o, 16'h0085);
        zero_extend_op_i = 1'b0;
        idle;
        $display("extend test done");
    endtask
    // Register-side writes: strobes are combinational, so look before the edge
    task automatic t_sfr;
        wr_mode_i = 2'd3;
        wr_pointer_i = 16'h0021;
        wr_byte_i = 1'b1;
        wr_data_i = 16'h005a;
        wr_valid_i = 1'b1;
        #1;
        chk("reg write", sfr_wr_en_o, 1'b1);
        chk("reg strobe", sfr_byte_strobe_o, 2'b10);
        chk("reg wdata", sfr_wdata_o, 16'h5a5a);
        chk("write address", wr_effective_byte_address_o, 16'h0021);
        @(negedge sys_clk_i);
        chk("write post inc", wr_next_pointer_o, 16'h0022);
        wr_byte_i = 1'b0;
        wr_pointer_i = 16'h0023;
        #1;
        chk("reg write blocked", {sfr_wr_en_o, sfr_byte_strobe_o}, 3'b000);
        @(negedge sys_clk_i);
        chk("word post inc", wr_next_pointer_o, 16'h0025);
        chk("reg fault", {addr_error_o, addr_error_write_o}, 2'b11);
        wr_mode_i = 2'd0;
        idle;
        $display("register test done");
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Whole run needs under 100 cycles; the ceiling leaves ample slack
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        {rd_valid_i, rd_byte_i, wr_valid_i, wr_byte_i, sign_extend_op_i, zero_extend_op_i} = '0;
        {pc_advance_i, pc_load_i, rd_mode_i, wr_mode_i, rd_near_addr_i, wr_near_addr_i} = '0;
        {rd_direct_addr_i, rd_pointer_i, wr_direct_addr_i, wr_pointer_i, wr_data_i, wreg_old_i} = '0;
        pc_load_addr_i = '0;
        pm_word_i = 24'habcdef;
        sys_rst_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        @(negedge sys_clk_i);
        t_program;
        t_data;
        t_extend;
        t_sfr;
        end_sim;
    end
endmodule
`default_nettype wire
